/* File: design/iae_pkg.sv */
// Purpose: constants for the register add decode/execute block
// Assumes: 32-bit instruction words, plain register port
// Notes:   all offsets and fields, and the ctrl and mask reset values, live here
//
// Overview of operation
// - accepted instruction words are 32 bits and word aligned.
// - every mandatory-class instruction is always present.
// - optional-class instructions may be built in, partly, or left out.
// - add is major 0x38, sub 0x0, function 0x0; bits 10, 7:4 reserved.
// - destination bits 25:21, first source 20:16, second 15:11.
// - destination gets the sum of both source registers.
// - 32-bit build adds bits 31:0 into bits 31:0.
// - 64-bit build adds bits 63:0 into bits 63:0.
// - carry_flag set on unsigned overflow of the sum.
// - signed_wrap_flag set on signed overflow of the sum.
// - range trap on signed overflow when both enables are set.
// - range trap on carry when range and unsigned enables are set.
// - register add is mandatory, so it is always supported.

package iae_pkg;

  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [7:0] IAE_CTRL_OFS  = 8'h00;
  localparam logic [7:0] IAE_FLAGS_OFS = 8'h04;
  localparam logic [7:0] IAE_STAT_OFS  = 8'h08;
  localparam logic [7:0] IAE_MASK_OFS  = 8'h0C;
  localparam logic [7:0] IAE_COUNT_OFS = 8'h10;

  // ***********************************************************
  // register fields and reset values
  // ***********************************************************
  localparam int IAE_CTRL_W        = 3;
  localparam int IAE_CTRL_RANGE    = 0;
  localparam int IAE_CTRL_SIGNED   = 1;
  localparam int IAE_CTRL_UNSIGNED = 2;
  localparam int IAE_FLAG_CY       = 0;
  localparam int IAE_FLAG_OV       = 1;
  localparam int IAE_IRQ_W         = 2;
  localparam int IAE_IRQ_RANGE     = 0;
  localparam int IAE_IRQ_REJECT    = 1;
  localparam logic [2:0] IAE_CTRL_RST = 3'h0;
  localparam logic [1:0] IAE_MASK_RST = 2'h0;

  // ***********************************************************
  // instruction word layout
  // ***********************************************************
  localparam int IAE_MAJ_LO     = 26;
  localparam int IAE_MAJ_W      = 6;
  localparam int IAE_DST_LO     = 21;
  localparam int IAE_SRA_LO     = 16;
  localparam int IAE_SRB_LO     = 11;
  localparam int IAE_SUB_LO     = 8;
  localparam int IAE_SUB_W      = 2;
  localparam int IAE_FN_LO      = 0;
  localparam int IAE_FN_W       = 4;
  localparam int IAE_IDX_W      = 5;
  localparam int IAE_ALIGN_BITS = 2;
  localparam logic [5:0] IAE_OPC_MAJOR = 6'h38;
  localparam logic [1:0] IAE_OPC_SUB   = 2'h0;
  localparam logic [3:0] IAE_FN_ADD    = 4'h0;
  localparam logic [3:0] IAE_FN_ADDC   = 4'h1;

endpackage

/* File: design/iae_core.sv */
// Purpose: decode and execute the register-to-register add
// Assumes: operands arrive with the instruction from issue
// Notes:   one cycle from issue to writeback, no stalls
//
// Design decisions made here: the strobed register port and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

module iae_core import iae_pkg::*; #(
  parameter int XLEN     = 32,
  parameter int ADDR_W   = 32,
  parameter bit HAS_ADDC = 1'b0
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              ce_i,
  input  wire logic              issue_valid_i,
  input  wire logic [31:0]       instr_i,
  input  wire logic [ADDR_W-1:0] instr_addr_i,
  input  wire logic [XLEN-1:0]   src_a_val_i,
  input  wire logic [XLEN-1:0]   src_b_val_i,
  output logic                   wb_valid_o,
  output logic [4:0]             wb_dest_o,
  output logic [XLEN-1:0]        wb_data_o,
  output logic [4:0]             src_a_idx_o,
  output logic [4:0]             src_b_idx_o,
  output logic                   carry_flag_o,
  output logic                   signed_wrap_flag_o,
  output logic                   range_exc_o,
  output logic                   reject_o,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [31:0]            reg_rdata_o,
  output logic                   irq_o
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic                  wb_valid;
    logic [IAE_IDX_W-1:0]  dest;
    logic [XLEN-1:0]       data;
    logic [IAE_IDX_W-1:0]  ia;
    logic [IAE_IDX_W-1:0]  ib;
    logic                  cy;
    logic                  ov;
    logic                  rexc;
    logic                  rej;
    logic [IAE_CTRL_W-1:0] ctrl;
    logic [IAE_IRQ_W-1:0]  stat;
    logic [IAE_IRQ_W-1:0]  mask;
    logic [31:0]           cnt;
    logic [31:0]           rdata;
    logic                  irq;
  } iae_state_t;

  iae_state_t s_r;
  iae_state_t s_nxt;

  // ***********************************************************
  // helpers
  // ***********************************************************
  // register-format match on major, sub and function fields
  function automatic logic iae_is_rr(input logic [31:0] w,
                                     input logic [3:0]  fn);
    return (w[IAE_MAJ_LO +: IAE_MAJ_W] == IAE_OPC_MAJOR) &&
           (w[IAE_SUB_LO +: IAE_SUB_W] == IAE_OPC_SUB) &&
           (w[IAE_FN_LO +: IAE_FN_W] == fn);
  endfunction

  // five-bit register index at a given position
  function automatic logic [4:0] iae_idx(input logic [31:0] w,
                                         input int          lo);
    return w[lo +: IAE_IDX_W];
  endfunction

  logic            is_add;
  logic            is_addc;
  logic            misalign;
  logic            take;
  logic            cin;
  logic [XLEN:0]   sum;
  logic            ovf;
  logic            trap;
  logic [IAE_IRQ_W-1:0] ev;
  logic            stat_rd;

  // ***********************************************************
  // next-state logic
  // ***********************************************************
  always_comb begin
    s_nxt = s_r;
    // reserved bits 10 and 7:4 are ignored, not checked
    is_add  = iae_is_rr(instr_i, IAE_FN_ADD);
    // the carry form is optional and only built on request
    is_addc = HAS_ADDC && iae_is_rr(instr_i, IAE_FN_ADDC);
    // low address bits must be zero for a word fetch
    misalign = instr_addr_i[IAE_ALIGN_BITS-1:0] != '0;
    take = issue_valid_i && !misalign && (is_add || is_addc);
    cin  = is_addc && s_r.cy;
    // one extra bit catches the unsigned carry out
    sum = {1'b0, src_a_val_i} + {1'b0, src_b_val_i}
        + {{XLEN{1'b0}}, cin};
    // signed wrap: equal operand signs, differing result sign
    ovf = (src_a_val_i[XLEN-1] == src_b_val_i[XLEN-1]) &&
          (sum[XLEN-1] != src_a_val_i[XLEN-1]);
    trap = s_r.ctrl[IAE_CTRL_RANGE] &&
           ((s_r.ctrl[IAE_CTRL_SIGNED] && ovf) ||
            (s_r.ctrl[IAE_CTRL_UNSIGNED] && sum[XLEN]));

    // writeback and pulses last exactly one cycle
    s_nxt.wb_valid = take;
    s_nxt.rexc     = take && trap;
    s_nxt.rej      = issue_valid_i && !take;
    if (take) begin
      s_nxt.dest = iae_idx(instr_i, IAE_DST_LO);
      s_nxt.ia   = iae_idx(instr_i, IAE_SRA_LO);
      s_nxt.ib   = iae_idx(instr_i, IAE_SRB_LO);
      s_nxt.data = sum[XLEN-1:0];
      // both flags rewritten, so a clean add clears them
      s_nxt.cy   = sum[XLEN];
      s_nxt.ov   = ovf;
      s_nxt.cnt  = s_r.cnt + 32'h0000_0001;
    end

    // software writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        IAE_CTRL_OFS: s_nxt.ctrl = reg_wdata_i[IAE_CTRL_W-1:0];
        IAE_MASK_OFS: s_nxt.mask = reg_wdata_i[IAE_IRQ_W-1:0];
        default: ;
      endcase
    end

    // read data stands only in the cycle after the strobe
    s_nxt.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        IAE_CTRL_OFS:
          s_nxt.rdata = {{(32-IAE_CTRL_W){1'b0}}, s_r.ctrl};
        IAE_FLAGS_OFS: begin
          s_nxt.rdata[IAE_FLAG_CY] = s_r.cy;
          s_nxt.rdata[IAE_FLAG_OV] = s_r.ov;
        end
        IAE_STAT_OFS:
          s_nxt.rdata = {{(32-IAE_IRQ_W){1'b0}}, s_r.stat};
        IAE_MASK_OFS:
          s_nxt.rdata = {{(32-IAE_IRQ_W){1'b0}}, s_r.mask};
        IAE_COUNT_OFS: s_nxt.rdata = s_r.cnt;
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // sticky events; a new event beats the read clear
    ev = '0;
    ev[IAE_IRQ_RANGE]  = s_nxt.rexc;
    ev[IAE_IRQ_REJECT] = s_nxt.rej;
    stat_rd = reg_rd_i && (reg_addr_i == IAE_STAT_OFS);
    s_nxt.stat = (stat_rd ? '0 : s_r.stat) | ev;
    // taken from next state so irq leaves a flop with no lag
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  // clock enable low freezes every bit of state
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r      <= '0;
      s_r.ctrl <= IAE_CTRL_RST;
      s_r.mask <= IAE_MASK_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  // every output is a field of the registered state
  assign wb_valid_o         = s_r.wb_valid;
  assign wb_dest_o          = s_r.dest;
  assign wb_data_o          = s_r.data;
  assign src_a_idx_o        = s_r.ia;
  assign src_b_idx_o        = s_r.ib;
  assign carry_flag_o       = s_r.cy;
  assign signed_wrap_flag_o = s_r.ov;
  assign range_exc_o        = s_r.rexc;
  assign reject_o           = s_r.rej;
  assign reg_rdata_o        = s_r.rdata;
  assign irq_o              = s_r.irq;

  // ***********************************************************
  // checks
  // ***********************************************************
  // independent reference sum without carry-in
  logic [XLEN:0] h_sum;
  logic          h_add;
  logic          h_ov;
  assign h_sum = {1'b0, src_a_val_i} + {1'b0, src_b_val_i};
  assign h_add = ce_i && issue_valid_i && is_add && !misalign;
  assign h_ov  = (src_a_val_i[XLEN-1] == src_b_val_i[XLEN-1]) &&
                 (h_sum[XLEN-1] != src_a_val_i[XLEN-1]);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  add_writeback_a: assert property (
    h_add |=> wb_valid_o && !reject_o &&
      wb_dest_o == $past(instr_i[25:21]) &&
      src_a_idx_o == $past(instr_i[20:16]) &&
      src_b_idx_o == $past(instr_i[15:11]))
    else $error("add not written back with decoded indices");

  sum_value_a: assert property (
    h_add |=> wb_data_o == $past(h_sum[XLEN-1:0]))
    else $error("writeback data is not the operand sum");

  carry_flag_a: assert property (
    h_add |=> carry_flag_o == $past(h_sum[XLEN]))
    else $error("carry flag does not follow unsigned carry");

  wrap_flag_a: assert property (
    h_add |=> signed_wrap_flag_o == $past(h_ov))
    else $error("signed wrap flag does not follow overflow");

  range_trap_a: assert property (
    h_add |=> range_exc_o == $past(s_r.ctrl[IAE_CTRL_RANGE] &&
      ((s_r.ctrl[IAE_CTRL_SIGNED] && h_ov) ||
       (s_r.ctrl[IAE_CTRL_UNSIGNED] && h_sum[XLEN]))))
    else $error("range exception mismatch");

  misalign_rej_a: assert property (
    ce_i && issue_valid_i && instr_addr_i[1:0] != 2'h0
      |=> reject_o && !wb_valid_o && $stable(carry_flag_o))
    else $error("misaligned instruction was executed");

  addc_absent_a: assert property (
    ce_i && issue_valid_i && !HAS_ADDC &&
      iae_is_rr(instr_i, IAE_FN_ADDC)
      |=> reject_o && !wb_valid_o)
    else $error("absent optional instruction was accepted");

  flags_hold_a: assert property (
    ce_i && !issue_valid_i |=> !wb_valid_o &&
      $stable(carry_flag_o) && $stable(signed_wrap_flag_o))
    else $error("flags changed without an executed add");

  stat_read_a: assert property (
    ce_i && reg_rd_i && reg_addr_i == IAE_STAT_OFS && !issue_valid_i
      |=> reg_rdata_o[1:0] == $past(s_r.stat) && s_r.stat == 2'h0)
    else $error("status read did not return and clear");

  // ***********************************************************
  // checks on pulses, holding and the register port
  // ***********************************************************
  // a low clock enable must leave every state bit untouched
  ce_freeze_a: assert property (
    !ce_i |=> $stable(s_r))
    else $error("state moved while clock enable was low");

  // decode from raw bit positions, not from the helper function
  raw_decode_a: assert property (
    ce_i && issue_valid_i && instr_addr_i[1:0] == 2'h0 &&
      instr_i[31:26] == 6'h38 && instr_i[9:8] == 2'h0 &&
      instr_i[3:0] == 4'h0
      |=> wb_valid_o && !reject_o)
    else $error("well formed add was not executed");

  wrong_major_a: assert property (
    ce_i && issue_valid_i && instr_i[31:26] != 6'h38
      |=> reject_o && !wb_valid_o)
    else $error("foreign major opcode was executed");

  wrong_sub_a: assert property (
    ce_i && issue_valid_i && instr_i[9:8] != 2'h0
      |=> reject_o && !wb_valid_o)
    else $error("foreign sub opcode was executed");

  // pulses last one cycle when nothing new is offered
  pulse_end_a: assert property (
    ce_i && !issue_valid_i
      |=> !wb_valid_o && !range_exc_o && !reject_o)
    else $error("execute pulse outlived its cycle");

  wb_or_rej_a: assert property (
    !(wb_valid_o && reject_o))
    else $error("writeback and reject at once");

  exc_with_wb_a: assert property (
    range_exc_o |-> wb_valid_o)
    else $error("range exception without a writeback");

  // result stays put between executed adds
  data_hold_a: assert property (
    ce_i && !issue_valid_i
      |=> $stable(wb_data_o) && $stable(wb_dest_o))
    else $error("writeback data moved without an add");

  count_step_a: assert property (
    h_add |=> s_r.cnt == $past(s_r.cnt) + 32'h0000_0001)
    else $error("add counter did not step by one");

  // sticky bits rise with the pulse that sets them
  stat_range_a: assert property (
    range_exc_o |-> s_r.stat[IAE_IRQ_RANGE])
    else $error("range status bit missing");

  stat_reject_a: assert property (
    reject_o |-> s_r.stat[IAE_IRQ_REJECT])
    else $error("reject status bit missing");

  irq_level_a: assert property (
    irq_o == |(s_r.stat & s_r.mask))
    else $error("interrupt does not match masked status");

  // read data must be zero outside the cycle after a read
  rdata_idle_a: assert property (
    ce_i && !reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data stands without a read");

  ctrl_write_a: assert property (
    ce_i && reg_wr_i && reg_addr_i == IAE_CTRL_OFS
      |=> s_r.ctrl == $past(reg_wdata_i[2:0]))
    else $error("trap enable write did not land");

  mask_write_a: assert property (
    ce_i && reg_wr_i && reg_addr_i == IAE_MASK_OFS
      |=> s_r.mask == $past(reg_wdata_i[1:0]))
    else $error("mask write did not land");

endmodule

`default_nettype wire

/* File: dv/iae_gpr_model.sv */
// Purpose: register file standing in for issue and writeback
// Assumes: operands are read in the issue cycle
// Notes:   idle operand lines show inverted data
`timescale 1ns/1ps
`default_nettype none
module iae_gpr_model (
  input  wire logic        clk_i,
  input  wire logic        issue_valid_i,
  input  wire logic [31:0] instr_i,
  input  wire logic        wb_valid_i,
  input  wire logic [4:0]  wb_dest_i,
  input  wire logic [31:0] wb_data_i,
  output logic      [31:0] src_a_o,
  output logic      [31:0] src_b_o
);
  logic [31:0] regs [32];
  // inverted when idle, so a stale sample never looks right
  always_comb begin
    src_a_o = regs[instr_i[20:16]];
    src_b_o = regs[instr_i[15:11]];
    if (issue_valid_i !== 1'b1) begin
      src_a_o = ~src_a_o;
      src_b_o = ~src_b_o;
    end
  end
  // writeback lands on the edge after the pulse
  always @(posedge clk_i) begin
    if (wb_valid_i === 1'b1) begin
      regs[wb_dest_i] <= wb_data_i;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Purpose: self-checking bench for the register add block
// Assumes: ce_i high but for one frozen cycle, 32-bit build, no addc
// Notes:   expectations queued by drivers, popped by monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
  import iae_pkg::*;
  logic        clk_i, reset_n_i, iv, rw, rr, wbv, rej, cy, ov, exc, irq;
  logic [31:0] ins, ia, wd, rd_o, sa, sb, wdat, s;
  logic [7:0]  ra;
  logic [4:0]  dst, ixa, ixb;
  logic [51:0] exq [$];
  logic [31:0] rq [$];
  logic [1:0]  stat;
  logic [2:0]  ctl;
  logic        ecy, eov, rdp, ce;
  int          failures, checked, n_add;
  logic [31:0] bad [4] = '{32'h1, 32'h04000000, 32'h100, 32'h4F0};

  iae_core i_iae_core (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .issue_valid_i(iv), .instr_i(ins), .instr_addr_i(ia),
    .src_a_val_i(sa), .src_b_val_i(sb), .wb_valid_o(wbv),
    .wb_dest_o(dst), .wb_data_o(wdat), .src_a_idx_o(ixa),
    .src_b_idx_o(ixb), .carry_flag_o(cy), .signed_wrap_flag_o(ov),
    .range_exc_o(exc), .reject_o(rej), .reg_addr_i(ra),
    .reg_wdata_i(wd), .reg_wr_i(rw), .reg_rd_i(rr),
    .reg_rdata_o(rd_o), .irq_o(irq));
  iae_gpr_model i_iae_gpr_model (.clk_i(clk_i), .issue_valid_i(iv),
    .instr_i(ins), .wb_valid_i(wbv), .wb_dest_i(dst),
    .wb_data_i(wdat), .src_a_o(sa), .src_b_o(sb));

  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {1'b0, v[31:1]} ^ (v[0] ? 32'hA3000000 : 32'h0);
  endfunction
  function automatic logic [31:0] add(logic [4:0] d, a, b);
    return {IAE_OPC_MAJOR, d, a, b, 11'h0};
  endfunction
  task automatic cmp_exec(logic [51:0] e, g);
    checked++;
    if (e !== g) begin
      failures++;
      $display("wrong value exec result exp %h got %h", e, g);
    end
  endtask
  task automatic cmp_reg(string n, logic [31:0] e, g);
    checked++;
    if (e !== g) begin
      failures++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ***********************************************************
  // drivers
  // ***********************************************************
  task automatic idle;
    @(posedge clk_i);
    iv <= 1'b0;
    rw <= 1'b0;
    rr <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    iv <= 1'b0;
    rr <= 1'b0;
    rw <= 1'b1;
    ra <= a;
    wd <= d;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk_i);
    iv <= 1'b0;
    rw <= 1'b0;
    rr <= 1'b1;
    ra <= a;
    rq.push_back(e);
  endtask
  // expectation uses the operands that the design will sample
  task automatic issue(logic [31:0] w, logic [31:0] adr);
    logic [32:0] sum;
    logic ok, o, e;
    @(posedge clk_i);
    rw  <= 1'b0;
    rr  <= 1'b0;
    iv  <= 1'b1;
    ins <= w;
    ia  <= adr;
    #1;
    ok = w[31:26] == IAE_OPC_MAJOR && w[9:8] == IAE_OPC_SUB
      && w[3:0] == IAE_FN_ADD && adr[1:0] == 2'h0;
    sum = {1'b0, sa} + {1'b0, sb};
    o = sa[31] == sb[31] && sum[31] != sa[31];
    if (ok) begin
      ecy = sum[32];
      eov = o;
      n_add++;
    end
    e = ok && ctl[0] && (o && ctl[1] || sum[32] && ctl[2]);
    stat |= {!ok, e};
    exq.push_back({ok, !ok, e, ecy, eov, ok ? {w[25:21], w[20:16],
      w[15:11], sum[31:0]} : 47'h0});
  endtask
  task automatic drain;
    for (int k = 0; k < 20 && exq.size() + rq.size() > 0; k++) begin
      @(posedge clk_i);
    end
    if (exq.size() + rq.size() > 0) begin
      failures++;
      final_report;
    end
  endtask
  // ***********************************************************
  // monitor and clock
  // ***********************************************************
  always @(posedge clk_i) begin
    #1;
    if (wbv === 1'b1 || rej === 1'b1) begin
      if (exq.size() == 0) cmp_exec(52'h0, 52'h1);
      else cmp_exec(exq.pop_front(), {wbv, rej, exc, cy, ov, wbv ?
        {dst, ixa, ixb, wdat} : 47'h0});
    end
    if (rdp) cmp_reg("reg read", rq.pop_front(), rd_o);
    rdp = rr;
  end
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // a hang ends the run with a counted mismatch
  initial begin
    #200000;
    failures++;
    final_report;
  end
  // ***********************************************************
  // scenarios
  // ***********************************************************
  initial begin
    {reset_n_i, iv, rw, rr, ins, ia, ra, wd} = '0;
    ce = 1'b1;
    {failures, checked, n_add, stat, ctl, ecy, eov, rdp} = '0;
    s = 32'h00016FF7;
    for (int i = 0; i < 32; i++) begin
      s = lfsr(s);
      i_iae_gpr_model.regs[i] = s;
    end
    i_iae_gpr_model.regs[1] = 32'hFFFFFFFF;
    i_iae_gpr_model.regs[2] = 32'h1;
    i_iae_gpr_model.regs[3] = 32'h7FFFFFFF;
    i_iae_gpr_model.regs[4] = 32'h80000000;
    i_iae_gpr_model.regs[5] = 32'h0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // reset values and an unmapped hole
    rd(IAE_CTRL_OFS, 32'h0);
    rd(IAE_FLAGS_OFS, 32'h0);
    rd(IAE_MASK_OFS, 32'h0);
    rd(8'h14, 32'h0);
    // every trap enable mix against carry-only and wrap-only sums
    for (int c = 0; c < 8; c++) begin
      wr(IAE_CTRL_OFS, 32'(c));
      ctl = 3'(c);
      idle;
      issue(add(6, 1, 2), 32'h0);
      issue(add(7, 3, 3), 32'h4);
    end
    // both flags set, then both cleared by a quiet sum
    issue(add(8, 4, 4), 32'h8);
    issue(add(9, 5, 5), 32'hC);
    // refused words and reserved bits that must be ignored
    for (int k = 0; k < 4; k++) issue(add(10, 1, 2) ^ bad[k], 32'h40);
    issue(add(10, 1, 2), 32'h42);
    // random back-to-back traffic, dependent operands included
    for (int k = 0; k < 16; k++) begin
      s = lfsr(s);
      issue(add(s[4:0], s[9:5], s[14:10]), {s[29:0], 2'h0});
    end
    idle;
    drain;
    // sticky status, masking and read-clear
    wr(IAE_MASK_OFS, 32'h1);
    idle;
    idle;
    cmp_reg("irq", {31'h0, stat[0]}, {31'h0, irq});
    rd(IAE_STAT_OFS, {30'h0, stat});
    stat = 2'h0;
    rd(IAE_STAT_OFS, 32'h0);
    rd(IAE_COUNT_OFS, 32'(n_add));
    rd(IAE_FLAGS_OFS, {30'h0, eov, ecy});
    rd(IAE_CTRL_OFS, 32'h7);
    wr(IAE_MASK_OFS, 32'h2);
    idle;
    drain;
    cmp_reg("irq", 32'h0, {31'h0, irq});
    issue(add(10, 1, 2), 32'h2);
    idle;
    drain;
    idle;
    cmp_reg("irq", 32'h1, {31'h0, irq});
    // an add offered with clock enable low must leave no trace
    @(posedge clk_i);
    ce  <= 1'b0;
    iv  <= 1'b1;
    ins <= add(11, 1, 2);
    ia  <= 32'h0;
    @(posedge clk_i);
    iv <= 1'b0;
    ce <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd(IAE_COUNT_OFS, 32'(n_add));
    idle;
    drain;
    final_report;
  end
endmodule
`default_nettype wire
